// File: inc/sbc_cfg.svh
// register offsets, field positions, reset values and sizes of the spi buffer block
// assumes inclusion by every design file of the block; definitions only
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH

// ----------------------------------------------------------------
// register offsets (plain port, byte addresses)
// ----------------------------------------------------------------
`define SBC_ADDR_W         4
`define SBC_OFS_RXDATA     4'h0
`define SBC_OFS_TXDATA     4'h1
`define SBC_OFS_CLKSRC     4'h2
`define SBC_OFS_INTF       4'h3
`define SBC_OFS_INTE       4'h4
`define SBC_OFS_TCNTH      4'h5
`define SBC_OFS_TCNTL      4'h6
`define SBC_OFS_TWIDTH     4'h7
`define SBC_OFS_BAUD       4'h8
`define SBC_OFS_CTRL0      4'h9
`define SBC_OFS_CTRL1      4'ha
`define SBC_OFS_CTRL2      4'hb
`define SBC_OFS_STATUS     4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SBC_ST_TX_WRITE_ERROR        7
`define SBC_ST_TX_QUEUE_EMPTY        5
`define SBC_ST_RX_READ_ERROR        3
`define SBC_ST_FLUSH_BUFFERS       2
`define SBC_ST_RX_QUEUE_FULL        0
`define SBC_IF_SHIFT_EMPTY 7
`define SBC_IF_COUNT_ZERO  6
`define SBC_IF_SEL_START   5
`define SBC_IF_SEL_END     4
`define SBC_IF_RX_OVERFLOW 2
`define SBC_IF_TX_UNDERFL  1
`define SBC_C2_BUSY        7
`define SBC_C2_SSFLT       6

// ----------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------
`define SBC_INTF_MASK      8'hf6
`define SBC_CTRL0_MASK     8'h87
`define SBC_CTRL1_MASK     8'hf7
`define SBC_CTRL1_RESET    8'h04
`define SBC_CLKSRC_MASK    8'h0f
`define SBC_TCNTH_MASK     8'h07
`define SBC_TWIDTH_MASK    8'h07
`define SBC_CTRL2_MASK     8'h07

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define SBC_FIFO_DEPTH     2
`define SBC_DATA_W         8
`define SBC_SRC_COUNT      9

`endif

// File: inc/sbc_pkg.sv
// types shared by the spi buffer block
// assumes nothing beyond a simulator that compiles it before the modules
package sbc_pkg;

   // bit clock sources; codes 9 to 15 select no source
   typedef enum logic [3:0] {
      sbc_src_system_oscillator   = 4'h0,
      sbc_src_fast_internal_osc   = 4'h1,
      sbc_src_medium_internal_osc = 4'h2,
      sbc_src_reference_clock_out = 4'h3,
      sbc_src_timer0_overflow     = 4'h4,
      sbc_src_timer2_postscaled   = 4'h5,
      sbc_src_timer4_postscaled   = 4'h6,
      sbc_src_timer6_postscaled   = 4'h7,
      sbc_src_measure_timer_match = 4'h8
   } sbc_clk_src_t;

endpackage

// File: hdl/sbc_fifo.sv
// byte queue held in flip-flops, with flush, used for both data directions
// assumes push and pop come from logic on ref_clk
`include "sbc_cfg.svh"

module sbc_fifo
   import sbc_pkg::*;
#(
   parameter int DEPTH = `SBC_FIFO_DEPTH,
   parameter int WIDTH = `SBC_DATA_W
)
(
   input  wire logic                       ref_clk,
   input  wire logic                       rst,
   input  wire logic                       flush,
   input  wire logic                       push,
   input  wire logic [WIDTH-1:0]           push_data,
   input  wire logic                       pop,
   output logic      [WIDTH-1:0]           head,
   output logic      [$clog2(DEPTH+1)-1:0] count,
   output logic                            full,
   output logic                            empty
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
      $error("sbc_fifo: depth and width must be at least one");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [CW-1:0]               count;
   } sbc_fifo_state_t;

   sbc_fifo_state_t st;
   sbc_fifo_state_t next_st;

   function automatic logic [PW-1:0] sbc_wrap(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   logic do_push;
   logic do_pop;

   assign empty   = (st.count == '0);
   assign full    = (st.count == CW'(DEPTH));
   assign head    = empty ? '0 : st.mem[st.rd_ptr];
   assign count   = st.count;
   // a full queue refuses a push even when a pop leaves the same cycle
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;

   always_comb begin
      next_st = st;
      if (flush) begin
         next_st.wr_ptr = '0;
         next_st.rd_ptr = '0;
         next_st.count  = '0;
      end else begin
         if (do_push) begin
            next_st.mem[st.wr_ptr] = push_data;
            next_st.wr_ptr         = sbc_wrap(st.wr_ptr);
         end
         if (do_pop) begin
            next_st.rd_ptr = sbc_wrap(st.rd_ptr);
         end
         if (do_push && !do_pop) begin
            next_st.count = st.count + CW'(1);
         end else if (do_pop && !do_push) begin
            next_st.count = st.count - CW'(1);
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule

// File: hdl/sbc_clk_select.sv
// bit clock source selection: synchronises every source and marks rising edges
// assumes sources are slow against ref_clk (two ref_clk periods per level at least)
`include "sbc_cfg.svh"

module sbc_clk_select
   import sbc_pkg::*;
(
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic [`SBC_SRC_COUNT-1:0] src_in,
   input  wire logic [3:0]                select,
   output logic                           bit_clk_tick,
   output logic                           bit_clk_level
);

   typedef struct packed {
      logic [`SBC_SRC_COUNT-1:0] sync1;
      logic [`SBC_SRC_COUNT-1:0] sync2;
      logic                      level;
      logic                      tick;
   } sbc_clk_state_t;

   sbc_clk_state_t st;
   sbc_clk_state_t next_st;

   logic sel_level;

   // reserved codes pick no source, so the tick stays low
   always_comb begin
      sel_level = 1'b0;
      if (select <= sbc_src_measure_timer_match) begin
         sel_level = st.sync2[select];
      end
   end

   always_comb begin
      next_st       = st;
      next_st.sync1 = src_in;
      next_st.sync2 = st.sync1;
      next_st.level = sel_level;
      next_st.tick  = sel_level && !st.level;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign bit_clk_tick  = st.tick;
   assign bit_clk_level = st.level;

endmodule

// File: hdl/sbc_spi_buffer.sv
// register file, byte queues and clock selection of the spi controller
// assumes a register master on ref_clk and a shift engine on ref_clk at the queues
//
// The address-and-strobe port and the address map were left to the implementer.
`include "sbc_cfg.svh"

module sbc_spi_buffer
   import sbc_pkg::*;
#(
   parameter int DEPTH = `SBC_FIFO_DEPTH
)
(
   input  wire logic                      ref_clk,
   input  wire logic                      rst,
   input  wire logic [`SBC_ADDR_W-1:0]    reg_addr,
   input  wire logic [7:0]                reg_wdata,
   input  wire logic                      reg_wr,
   input  wire logic                      reg_rd,
   output logic      [7:0]                reg_rdata,
   output logic                           irq,
   input  wire logic [`SBC_SRC_COUNT-1:0] clk_src_in,
   output logic                           bit_clk_tick,
   output logic                           bit_clk_level,
   input  wire logic                      rx_push,
   input  wire logic [7:0]                rx_push_data,
   output logic                           rx_push_ready,
   input  wire logic                      tx_pop,
   output logic                           tx_pop_valid,
   output logic      [7:0]                tx_pop_data,
   input  wire logic                      evt_shift_empty,
   input  wire logic                      evt_count_zero,
   input  wire logic                      evt_select_start,
   input  wire logic                      evt_select_end,
   input  wire logic                      evt_rx_overflow,
   input  wire logic                      evt_tx_underflow,
   input  wire logic                      engine_busy,
   input  wire logic                      select_fault,
   output logic      [7:0]                cfg_ctrl0,
   output logic      [7:0]                cfg_ctrl1,
   output logic      [2:0]                cfg_ctrl2,
   output logic      [7:0]                cfg_baud,
   output logic      [10:0]               cfg_count,
   output logic      [2:0]                cfg_width
);

   localparam int CW = $clog2(DEPTH + 1);

   if (DEPTH < 1) begin : g_bad_depth
      $error("sbc_spi_buffer: queue depth must be at least one");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] rdata;
      logic       tx_write_error;
      logic       rx_read_error;
      logic [7:0] intf;
      logic [7:0] inte;
      logic [3:0] bit_clock_select;
      logic [2:0] tcnt_high;
      logic [7:0] tcnt_low;
      logic [2:0] twidth;
      logic [7:0] baud;
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [2:0] ctrl2;
      logic       irq;
   } sbc_regs_t;

   sbc_regs_t st;
   sbc_regs_t next_st;

   function automatic logic sbc_hit(input logic             strobe,
                                    input logic [3:0]       addr,
                                    input logic [3:0]       ofs);
      return strobe && (addr == ofs);
   endfunction

   // ----------------------------------------------------------------
   // queues
   // ----------------------------------------------------------------
   logic          flush;
   logic          rx_pop;
   logic          tx_push;
   logic [7:0]    rx_head;
   logic [CW-1:0] rx_count;
   logic [CW-1:0] tx_count;
   logic          rx_full;
   logic          rx_empty;
   logic          tx_full;
   logic          tx_empty;

   assign flush   = sbc_hit(reg_wr, reg_addr, `SBC_OFS_STATUS) && reg_wdata[`SBC_ST_FLUSH_BUFFERS];
   assign rx_pop  = sbc_hit(reg_rd, reg_addr, `SBC_OFS_RXDATA) && !rx_empty;
   assign tx_push = sbc_hit(reg_wr, reg_addr, `SBC_OFS_TXDATA) && !tx_full;

   sbc_fifo #(.DEPTH(DEPTH), .WIDTH(`SBC_DATA_W)) u_rx_queue (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .flush     (flush),
      .push      (rx_push),
      .push_data (rx_push_data),
      .pop       (rx_pop),
      .head      (rx_head),
      .count     (rx_count),
      .full      (rx_full),
      .empty     (rx_empty)
   );

   sbc_fifo #(.DEPTH(DEPTH), .WIDTH(`SBC_DATA_W)) u_tx_queue (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .flush     (flush),
      .push      (tx_push),
      .push_data (reg_wdata),
      .pop       (tx_pop),
      .head      (tx_pop_data),
      .count     (tx_count),
      .full      (tx_full),
      .empty     (tx_empty)
   );

   assign rx_push_ready = !rx_full;
   assign tx_pop_valid  = !tx_empty;

   sbc_clk_select u_clk_select (
      .ref_clk       (ref_clk),
      .rst           (rst),
      .src_in        (clk_src_in),
      .select        (st.bit_clock_select),
      .bit_clk_tick  (bit_clk_tick),
      .bit_clk_level (bit_clk_level)
   );

   // ----------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------
   logic [7:0] events;
   logic [7:0] status_view;
   logic [7:0] read_value;

   always_comb begin
      events                      = 8'h00;
      events[`SBC_IF_SHIFT_EMPTY] = evt_shift_empty;
      events[`SBC_IF_COUNT_ZERO]  = evt_count_zero;
      events[`SBC_IF_SEL_START]   = evt_select_start;
      events[`SBC_IF_SEL_END]     = evt_select_end;
      events[`SBC_IF_RX_OVERFLOW] = evt_rx_overflow;
      events[`SBC_IF_TX_UNDERFL]  = evt_tx_underflow;
      status_view                 = 8'h00;
      status_view[`SBC_ST_TX_WRITE_ERROR]   = st.tx_write_error;
      status_view[`SBC_ST_TX_QUEUE_EMPTY]   = tx_empty;
      status_view[`SBC_ST_RX_READ_ERROR]   = st.rx_read_error;
      status_view[`SBC_ST_RX_QUEUE_FULL]   = rx_full;
   end

   // the transmit register and the flush bit read as zero
   always_comb begin
      case (reg_addr)
         `SBC_OFS_RXDATA: read_value = rx_head;
         `SBC_OFS_CLKSRC: read_value = {4'h0, st.bit_clock_select};
         `SBC_OFS_INTF:   read_value = st.intf;
         `SBC_OFS_INTE:   read_value = st.inte;
         `SBC_OFS_TCNTH:  read_value = {5'h00, st.tcnt_high};
         `SBC_OFS_TCNTL:  read_value = st.tcnt_low;
         `SBC_OFS_TWIDTH: read_value = {5'h00, st.twidth};
         `SBC_OFS_BAUD:   read_value = st.baud;
         `SBC_OFS_CTRL0:  read_value = st.ctrl0;
         `SBC_OFS_CTRL1:  read_value = st.ctrl1;
         `SBC_OFS_CTRL2:  read_value = {engine_busy, select_fault, 3'h0, st.ctrl2};
         `SBC_OFS_STATUS: read_value = status_view;
         default:         read_value = 8'h00;
      endcase
   end

   always_comb begin
      next_st       = st;
      next_st.rdata = reg_rd ? read_value : 8'h00;
      if (reg_wr) begin
         case (reg_addr)
            `SBC_OFS_CLKSRC: next_st.bit_clock_select = reg_wdata[3:0];
            `SBC_OFS_INTE:   next_st.inte = reg_wdata & `SBC_INTF_MASK;
            `SBC_OFS_TCNTH:  next_st.tcnt_high = reg_wdata[2:0];
            `SBC_OFS_TCNTL:  next_st.tcnt_low = reg_wdata;
            `SBC_OFS_TWIDTH: next_st.twidth = reg_wdata[2:0];
            `SBC_OFS_BAUD:   next_st.baud = reg_wdata;
            `SBC_OFS_CTRL0:  next_st.ctrl0 = reg_wdata & `SBC_CTRL0_MASK;
            `SBC_OFS_CTRL1:  next_st.ctrl1 = reg_wdata & `SBC_CTRL1_MASK;
            `SBC_OFS_CTRL2:  next_st.ctrl2 = reg_wdata[2:0];
            default:         next_st.ctrl2 = st.ctrl2;
         endcase
      end
      // write one to clear; a new event in the same cycle wins
      if (sbc_hit(reg_wr, reg_addr, `SBC_OFS_INTF)) begin
         next_st.intf = st.intf & ~reg_wdata;
      end
      next_st.intf = (next_st.intf | events) & `SBC_INTF_MASK;
      if (sbc_hit(reg_wr, reg_addr, `SBC_OFS_STATUS)) begin
         if (reg_wdata[`SBC_ST_TX_WRITE_ERROR]) begin
            next_st.tx_write_error = 1'b0;
         end
         if (reg_wdata[`SBC_ST_RX_READ_ERROR]) begin
            next_st.rx_read_error = 1'b0;
         end
      end
      if (sbc_hit(reg_wr, reg_addr, `SBC_OFS_TXDATA) && tx_full) begin
         next_st.tx_write_error = 1'b1;
      end
      if (sbc_hit(reg_rd, reg_addr, `SBC_OFS_RXDATA) && rx_empty) begin
         next_st.rx_read_error = 1'b1;
      end
      next_st.irq = |(next_st.intf & next_st.inte);
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st       <= '0;
         st.ctrl1 <= `SBC_CTRL1_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign irq       = st.irq;
   assign cfg_ctrl0 = st.ctrl0;
   assign cfg_ctrl1 = st.ctrl1;
   assign cfg_ctrl2 = st.ctrl2;
   assign cfg_baud  = st.baud;
   assign cfg_count = {st.tcnt_high, st.tcnt_low};
   assign cfg_width = st.twidth;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_rx_pop_order: assert property (
      (rx_pop && !rx_push && !flush)
      |=> (rx_count == $past(rx_count) - CW'(1)) && (reg_rdata == $past(rx_head)))
      else $error("receive read did not pop the oldest byte");

   a_rx_empty_read: assert property (
      (sbc_hit(reg_rd, reg_addr, `SBC_OFS_RXDATA) && rx_empty && !rx_push)
      |=> (reg_rdata == 8'h00) && st.rx_read_error && (rx_count == '0))
      else $error("empty receive read misbehaved");

   a_tx_append: assert property (
      (tx_push && !tx_pop && !flush) |=> tx_count == $past(tx_count) + CW'(1))
      else $error("transmit write did not append");

   a_tx_full_write: assert property (
      (sbc_hit(reg_wr, reg_addr, `SBC_OFS_TXDATA) && tx_full && !tx_pop && !flush)
      |=> st.tx_write_error && $stable(tx_count) && $stable(tx_pop_data))
      else $error("write to full transmit queue not refused");

   a_rx_write_ignored: assert property (
      (sbc_hit(reg_wr, reg_addr, `SBC_OFS_RXDATA) && !rx_push && !flush)
      |=> $stable(rx_count))
      else $error("write to receive register changed the queue");

   a_tick_source: assert property (
      bit_clk_tick |-> $past(st.bit_clock_select, 3) <= 4'h8 || $past(st.bit_clock_select) <= 4'h8)
      else $error("bit clock tick from a reserved source");

   a_intf_layout: assert property (
      sbc_hit(reg_rd, reg_addr, `SBC_OFS_INTF) |=> (reg_rdata & ~`SBC_INTF_MASK) == 8'h00)
      else $error("interrupt flags outside the layout");

   a_err_sticky: assert property (
      (st.tx_write_error && !(sbc_hit(reg_wr, reg_addr, `SBC_OFS_STATUS)
                              && reg_wdata[`SBC_ST_TX_WRITE_ERROR]))
      |=> st.tx_write_error)
      else $error("write error flag dropped without a clear");

   a_flush_empties: assert property (
      flush |=> (rx_count == '0) && (tx_count == '0))
      else $error("flush left data in a queue");

   a_status_view: assert property (
      sbc_hit(reg_rd, reg_addr, `SBC_OFS_STATUS)
      |=> (reg_rdata[`SBC_ST_TX_QUEUE_EMPTY] == $past(tx_empty))
          && (reg_rdata[`SBC_ST_RX_QUEUE_FULL] == $past(rx_full)))
      else $error("status does not show queue state");

endmodule

// File: verif/sbc_engine_model.sv
// shift engine stand-in: pushes received bytes, takes transmit bytes, runs the bit clock sources
// assumes ref_clk from the bench; one link clock of 400 ns period, gated onto each source line
`include "sbc_cfg.svh"

module sbc_engine_model
   import sbc_pkg::*;
(
   input  wire logic                      ref_clk,
   input  wire logic [`SBC_SRC_COUNT-1:0] src_en,
   input  wire logic                      tx_pop_valid,
   input  wire logic [7:0]                tx_pop_data,
   output logic                           rx_push,
   output logic      [7:0]                rx_push_data,
   output logic                           tx_pop,
   output logic      [`SBC_SRC_COUNT-1:0] clk_src_in
);
   timeunit 1ns;
   timeprecision 1ns;

   logic link_clk = 1'b0;

   initial begin
      rx_push = 1'b0;
      rx_push_data = 8'h00;
      tx_pop = 1'b0;
   end

   // free running, eight ref_clk periods long with edges on ref_clk falling edges; a disabled source stands low
   always #200 link_clk = ~link_clk;
   assign clk_src_in = src_en & {`SBC_SRC_COUNT{link_clk}};

   task automatic push(input logic [7:0] b);
      @(posedge ref_clk);
      rx_push <= 1'b1;
      rx_push_data <= b;
      @(posedge ref_clk);
      rx_push <= 1'b0;
      // released data shows no stale byte
      rx_push_data <= ~b;
   endtask

   task automatic pop(output logic [7:0] b, output logic v);
      @(posedge ref_clk);
      tx_pop <= 1'b1;
      #1;
      b = tx_pop_data;
      v = tx_pop_valid;
      @(posedge ref_clk);
      tx_pop <= 1'b0;
   endtask
endmodule

// File: verif/sbc_spi_buffer_tb_top.sv
// self-checking bench of the spi buffer block: register tasks, engine model, clock sources
// assumes the design files and sbc_pkg compiled first; sbc_cfg.svh on the include path
`include "sbc_cfg.svh"

module sbc_spi_buffer_tb_top
   import sbc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int         DEPTH = 2;
   localparam logic [3:0] RX    = `SBC_OFS_RXDATA;
   localparam logic [3:0] TX    = `SBC_OFS_TXDATA;
   localparam logic [3:0] ST    = `SBC_OFS_STATUS;
   localparam logic [3:0] CS    = `SBC_OFS_CLKSRC;
   localparam logic [3:0] IF    = `SBC_OFS_INTF;
   localparam logic [3:0] IE    = `SBC_OFS_INTE;

   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, tx_pop_data, rx_push_data, evt = 8'h00;
   logic       reg_wr = 1'b0, reg_rd = 1'b0, irq, bit_clk_tick, rx_push, tx_pop;
   logic       rx_push_ready, tx_pop_valid, busy = 1'b0, fault = 1'b0;
   logic [8:0] src_en = 9'h000, clk_src_in;
   logic [7:0] b;
   logic       v;
   int         n_mismatch = 0;
   int         cmp_count = 0;
   int         ticks;
   int         highs;
   logic       bit_clk_level;
   logic [7:0] cfg_ctrl0, cfg_ctrl1, cfg_baud;
   logic [2:0] cfg_ctrl2, cfg_width;
   logic [10:0] cfg_count;

   always #25 ref_clk = ~ref_clk;

   sbc_spi_buffer #(.DEPTH(DEPTH)) DUT (
      .ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .clk_src_in,
      .bit_clk_tick, .bit_clk_level, .rx_push, .rx_push_data, .rx_push_ready, .tx_pop,
      .tx_pop_valid, .tx_pop_data, .evt_shift_empty(evt[7]), .evt_count_zero(evt[6]),
      .evt_select_start(evt[5]), .evt_select_end(evt[4]), .evt_rx_overflow(evt[2]),
      .evt_tx_underflow(evt[1]), .engine_busy(busy), .select_fault(fault), .cfg_ctrl0,
      .cfg_ctrl1, .cfg_ctrl2, .cfg_baud, .cfg_count, .cfg_width);

   sbc_engine_model eng (.ref_clk, .src_en, .tx_pop_valid, .tx_pop_data, .rx_push,
      .rx_push_data, .tx_pop, .clk_src_in);

   // ----------------------------------------------------------------
   // register access and comparison
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // irq is registered from the next flag and enable values, so it changes on the same edge as they do
   task automatic irqchk(input logic exp);
      repeat (2) @(posedge ref_clk);
      #1;
      chk({7'h00, irq}, {7'h00, exp});
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #2ms;
      n_mismatch++;
      $display("run cut short by the watchdog");
      conclude();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      rdchk(ST, 8'h20);
      rdchk(`SBC_OFS_CTRL1, 8'h04);
      chk(cfg_ctrl1, 8'h04);
      rdchk(RX, 8'h00);
      rdchk(ST, 8'h28);
      rdchk(ST, 8'h28);
      wr(ST, 8'h08);
      rdchk(ST, 8'h20);
      $display("test reset and empty read done");

      for (int i = 0; i < DEPTH; i++) eng.push(8'(8'ha0 + i));
      rdchk(ST, 8'h21);
      chk({7'h00, rx_push_ready}, 8'h00);
      wr(RX, 8'h55);
      for (int i = 0; i < DEPTH; i++) rdchk(RX, 8'(8'ha0 + i));
      rdchk(ST, 8'h20);
      $display("test receive queue done");

      for (int i = 0; i < DEPTH; i++) wr(TX, 8'(8'h30 + i));
      rdchk(ST, 8'h00);
      wr(TX, 8'hff);
      rdchk(ST, 8'h80);
      rdchk(TX, 8'h00);
      for (int i = 0; i < DEPTH; i++) begin
         eng.pop(b, v);
         chk(b, 8'(8'h30 + i));
      end
      eng.pop(b, v);
      chk({7'h00, v}, 8'h00);
      rdchk(ST, 8'ha0);
      wr(ST, 8'h80);
      rdchk(ST, 8'h20);
      $display("test transmit queue done");

      wr(TX, 8'h11);
      eng.push(8'h22);
      wr(ST, 8'h00);
      rdchk(ST, 8'h00);
      wr(ST, 8'h04);
      rdchk(ST, 8'h20);
      rdchk(RX, 8'h00);
      wr(ST, 8'h08);
      $display("test flush done");

      foreach (b[k]) begin
         if (k == 0 || k == 3) continue;
         @(posedge ref_clk);
         evt[k] <= 1'b1;
         @(posedge ref_clk);
         evt[k] <= 1'b0;
         rdchk(IF, 8'(1 << k));
         irqchk(1'b0);
         wr(IE, 8'(1 << k));
         irqchk(1'b1);
         wr(IF, 8'(1 << k));
         irqchk(1'b0);
         rdchk(IF, 8'h00);
      end
      wr(IE, 8'hff);
      rdchk(IE, 8'hf6);
      wr(IE, 8'h00);
      busy <= 1'b1;
      fault <= 1'b1;
      wr(`SBC_OFS_CTRL2, 8'hff);
      rdchk(`SBC_OFS_CTRL2, 8'hc7);
      chk({5'h00, cfg_ctrl2}, 8'h07);
      wr(`SBC_OFS_TCNTH, 8'hff);
      wr(`SBC_OFS_TCNTL, 8'ha5);
      wr(`SBC_OFS_TWIDTH, 8'hff);
      wr(`SBC_OFS_BAUD, 8'h3c);
      wr(`SBC_OFS_CTRL0, 8'hff);
      wr(`SBC_OFS_CTRL1, 8'hff);
      rdchk(`SBC_OFS_TCNTH, 8'h07);
      rdchk(`SBC_OFS_TCNTL, 8'ha5);
      rdchk(`SBC_OFS_TWIDTH, 8'h07);
      rdchk(`SBC_OFS_BAUD, 8'h3c);
      rdchk(`SBC_OFS_CTRL0, 8'h87);
      rdchk(`SBC_OFS_CTRL1, 8'hf7);
      chk(cfg_count[7:0], 8'ha5);
      chk({5'h00, cfg_count[10:8]}, 8'h07);
      chk({5'h00, cfg_width}, 8'h07);
      chk(cfg_baud, 8'h3c);
      chk(cfg_ctrl0, 8'h87);
      chk(cfg_ctrl1, 8'hf7);
      wr(4'hf, 8'h5a);
      rdchk(4'hf, 8'h00);
      $display("test flags and registers done");

      // reserved codes run every source, so a tick there means a wrong pick
      for (int c = 0; c < 17; c++) begin
         src_en <= 9'h000;
         wr(CS, (c < 16) ? 8'(c) : 8'h03);
         rdchk(CS, (c < 16) ? 8'(c) : 8'h03);
         src_en <= (c < 9) ? 9'(1 << c) : ((c < 16) ? 9'h1ff : 9'h010);
         repeat (4) @(posedge ref_clk);
         ticks = 0;
         highs = 0;
         repeat (40) begin
            @(posedge ref_clk);
            #1;
            if (bit_clk_tick === 1'b1) ticks++;
            if (bit_clk_level === 1'b1) highs++;
         end
         chk((ticks >= 2) ? 8'h01 : 8'h00, (c < 9) ? 8'h01 : 8'h00);
         chk((highs >= 8) ? 8'h01 : 8'h00, (c < 9) ? 8'h01 : 8'h00);
      end
      $display("test clock select done");
      conclude();
   end
endmodule
